// File: adl_code_loader.sv
// Purpose: Receives 16-bit serial words and loads the 12-bit converter code.
// Assumes: Serial clock is far slower than i_mclk (160 ns against 20 ns).
// Notes: Pins other than i_mclk and i_rst_b pass two flip-flops; serial clock edges are found by sampling.
`timescale 1ns/100ps
module adl_code_loader (
  input wire logic i_mclk,
  input wire logic i_rst_b,
  input wire logic i_sclk,
  input wire logic i_cs_b,
  input wire logic i_sdi,
  input wire logic i_code_rst_b,
  input wire logic i_standby_input_n,
  input wire logic i_address_pin_2,
  input wire logic i_address_pin_1,
  input wire logic i_address_pin_0,
  output logic [adl_pkg::CODE_W-1:0] o_code,
  output logic o_load_pulse
);
  import adl_pkg::*;

  // Synchroniser stages for every pin except i_mclk and i_rst_b; the bit order follows raw_in below.
  logic [7:0] meta_q, sync_q;
  logic [7:0] raw_in;
  // Serial bundle after synchronisation and its copy from the cycle before.
  adl_link_t link_now, link_prev_q;
  // Address straps, taken from the synchroniser and held one cycle more.
  logic [2:0] pins_q, pins_d;
  logic rst_sync_b, sb_sync;
  // Word being shifted, the code that sets the output and the load marker.
  logic [WORD_W-1:0] shift_q, shift_d;
  logic [CODE_W-1:0] code_q, code_d;
  logic load_q, load_d;
  logic sclk_rise, cs_rise;

  // Checks the address field against the fixed zero and the pins.
  function automatic logic addr_match(input logic [WORD_W-1:0] w, input logic [2:0] pins);
    addr_match = (w[ADDR_TOP_POS:ADDR_LOW_POS] == {1'b0, pins});
  endfunction : addr_match

  // Finds a rising level between the previous and the present sample.
  function automatic logic rose_now(input logic now_lvl, input logic prev_lvl);
    rose_now = now_lvl & ~prev_lvl;
  endfunction : rose_now

  // Raw pin levels gathered for the two-stage synchroniser.
  always_comb
  begin
    raw_in = {i_sclk, i_cs_b, i_sdi, i_code_rst_b, i_standby_input_n,
      i_address_pin_2, i_address_pin_1, i_address_pin_0};
  end

  // Two-flip-flop synchroniser; the first stage feeds only the second.
  always_ff @(posedge i_mclk)
  begin
    meta_q <= raw_in;
    sync_q <= meta_q;
  end

  // Splits the synchronised pins into the serial bundle and the controls.
  always_comb
  begin
    link_now = '{sclk: sync_q[7], cs_b: sync_q[6], sdi: sync_q[5]};
    rst_sync_b = sync_q[4];
    sb_sync = sync_q[3];
  end

  // Straps may move on a board; they too pass the synchroniser first.
  always_comb
  begin
    pins_d = sync_q[2:0];
  end

  // Edge detection on the synchronised serial clock and chip select.
  always_comb
  begin
    sclk_rise = rose_now(link_now.sclk, link_prev_q.sclk) & ~link_now.cs_b;
    cs_rise = rose_now(link_now.cs_b, link_prev_q.cs_b);
  end

  // Next-state for the shift register and code register.
  always_comb
  begin
    shift_d = shift_q;
    code_d = code_q;
    load_d = 1'b0;
    // A new bit pushes the oldest one out at the top.
    if (sclk_rise)
    begin
      shift_d = {shift_q[WORD_W-2:0], link_now.sdi};
    end
    if (cs_rise && rst_sync_b && sb_sync && addr_match(shift_q, pins_q))
    begin
      code_d = shift_q[CODE_W-1:0];
      load_d = 1'b1;
    end
    // The code reset pin wins over a load in the same cycle.
    if (!rst_sync_b)
    begin
      code_d = CODE_RST;
    end
  end

  // State registers; system reset clears word, code and marker, sets the straps to 7 and select high; the code reset pin only the code.
  always_ff @(posedge i_mclk)
  begin
    if (!i_rst_b)
    begin
      shift_q <= WORD_RST;
      code_q <= CODE_RST;
      load_q <= 1'b0;
      pins_q <= PINS_RST;
      link_prev_q <= '{sclk: 1'b0, cs_b: 1'b1, sdi: 1'b0};
    end
    else
    begin
      shift_q <= shift_d;
      code_q <= code_d;
      load_q <= load_d;
      pins_q <= pins_d;
      link_prev_q <= link_now;
    end
  end

  // Outputs come straight from their registers.
  assign o_code = code_q;
  assign o_load_pulse = load_q;

  // A chip select rise with matching word loads the code next cycle.
  a_load_on_match: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (cs_rise && rst_sync_b && sb_sync && addr_match(shift_q, pins_q)) |=>
      (o_code == $past(shift_q[CODE_W-1:0]) && o_load_pulse))
    else $error("code not loaded on matching word");

  // A word with its first bit set never changes the code.
  a_top_bit_blocks: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (cs_rise && shift_q[ADDR_TOP_POS] && rst_sync_b) |=> $stable(o_code))
    else $error("code changed with top address bit set");

  // A word for another strap setting never changes the code.
  a_pin_mismatch: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (shift_q[ADDR_TOP_POS-1:ADDR_LOW_POS] != pins_q && rst_sync_b) |=> $stable(o_code))
    else $error("code changed on address mismatch");

  // Standby freezes the code.
  a_standby_holds: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!sb_sync && rst_sync_b) |=> $stable(o_code))
    else $error("code changed in standby");

  // The code reset pin clears the code one cycle after it is seen.
  a_reset_clears: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !rst_sync_b |=> (o_code == CODE_RST))
    else $error("code not cleared by reset pin");

  // Each serial clock rise moves the word up by one bit.
  a_shift_in: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    sclk_rise |=> (shift_q == {$past(shift_q[WORD_W-2:0]), $past(link_now.sdi)}))
    else $error("serial bit not shifted in");

  // Clocks seen while deselected leave the word alone.
  a_no_shift_idle: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    link_now.cs_b |=> $stable(shift_q))
    else $error("shift register moved while deselected");

  // Only a chip select rise may load a code.
  a_load_only_cs: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (!cs_rise && rst_sync_b) |=> ($stable(o_code) && !o_load_pulse))
    else $error("code changed without chip select rise");

  // A load marker never lasts longer than one cycle.
  a_pulse_single: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_load_pulse |=> !o_load_pulse)
    else $error("load pulse lasted more than one cycle");

  // Every load came from a word whose first bit was zero.
  a_load_top_zero: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_load_pulse |-> !$past(shift_q[ADDR_TOP_POS]))
    else $error("code loaded from word with top bit set");

  // Every load came from a word that named these straps.
  a_load_pins_match: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_load_pulse |-> ($past(shift_q[ADDR_TOP_POS-1:ADDR_LOW_POS]) == $past(pins_q)))
    else $error("code loaded for another address");

  // All twelve code bits arrive together with the load marker.
  a_load_whole_code: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    o_load_pulse |-> (o_code == $past(shift_q[CODE_W-1:0])))
    else $error("code loaded only in part");

  // Standby also suppresses the load marker.
  a_standby_no_load: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !sb_sync |=> !o_load_pulse)
    else $error("load marked during standby");

  // The code reset pin also suppresses the load marker.
  a_rst_pin_no_load: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    !rst_sync_b |=> !o_load_pulse)
    else $error("load marked during code reset");

  // Nothing loads while select simply stays high.
  a_idle_no_load: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    (link_now.cs_b && link_prev_q.cs_b) |=> !o_load_pulse)
    else $error("load marked with select idle");

  // The newest bit always lands at the bottom of the word.
  a_newest_bit_low: assert property (@(posedge i_mclk) disable iff (!i_rst_b)
    sclk_rise |=> (shift_q[0] == $past(link_now.sdi)))
    else $error("newest bit not at the bottom");
endmodule : adl_code_loader

// File: adl_pkg.sv
// Purpose: Shared constants and types for the addressed converter code loader.
// Assumes: One system clock samples every serial and control pin.
// Notes: Word layout is four address bits followed by twelve code bits.
package adl_pkg;
  localparam int WORD_W = 16;
  localparam int CODE_W = 12;
  localparam int ADDR_W = 4;
  localparam int ADDR_TOP_POS = 15;
  localparam int ADDR_LOW_POS = 12;
  localparam int SYNC_W = 2;
  localparam logic [CODE_W-1:0] CODE_RST = 12'h000;
  localparam logic [WORD_W-1:0] WORD_RST = 16'h0000;
  localparam logic [2:0] PINS_RST = 3'h7;

  // Serial pins after synchronisation, as one bundle.
  typedef struct packed {
    logic sclk;
    logic cs_b;
    logic sdi;
  } adl_link_t;
endpackage : adl_pkg

// File: adl_host_model.sv
// Purpose: Host master model that shifts words into the code loader.
// Assumes: Serial clock period of 160 ns, idle low outside frames.
// Notes: The data line is inverted once a word ends so stale bits never linger.
`timescale 1ns/100ps
module adl_host_model (
  output logic o_sclk,
  output logic o_cs_b,
  output logic o_sdi
);
  // The bus idles with select high and the clock standing low.
  initial
  begin
    o_sclk = 1'b0;
    o_cs_b = 1'b1;
    o_sdi = 1'b0;
  end
  // Shifts n bits most significant first, then raises select to end the word.
  task automatic send(input logic [31:0] w, input int n);
    o_cs_b = 1'b0;
    for (int i = n - 1; i >= 0; i--)
    begin
      o_sdi = w[i];
      #80 o_sclk = 1'b1;
      #80 o_sclk = 1'b0;
    end
    o_sdi = ~o_sdi;
    #80 o_cs_b = 1'b1;
    #100;
  endtask : send
  // Toggles the clock with select high; a listening device must ignore it.
  task automatic idle_clocks(input int n);
    o_sdi = 1'b1;
    repeat (n)
    begin
      #80 o_sclk = 1'b1;
      #80 o_sclk = 1'b0;
    end
    #80;
  endtask : idle_clocks
endmodule : adl_host_model

// File: adl_code_loader_tb.sv
// Purpose: Self-checking bench for the addressed converter code loader.
// Assumes: Address straps are static while a word is shifted.
// Notes: Each word is judged once select has been high for five cycles.
`timescale 1ns/100ps
module adl_code_loader_tb;
  import adl_pkg::*;
  typedef struct packed {
    logic [31:0] w;
    logic [5:0] n;
    logic [11:0] c;
    logic p;
  } adl_row_t;
  logic mclk = 1'b0;
  logic rst_b = 1'b0;
  logic crst_b = 1'b1;
  logic sb_n = 1'b1;
  logic [2:0] pins = 3'h5;
  logic sclk, cs_b, sdi, pulse, got;
  logic [CODE_W-1:0] code;
  int err_count = 0;
  int samples_checked = 0;
  adl_row_t rows [6] = '{'{32'h5fff, 16, 12'hfff, 1}, '{32'h5800, 16, 12'h800, 1},
    '{32'hd123, 16, 12'h800, 0}, '{32'h4456, 16, 12'h800, 0},
    '{32'ha5000, 20, 12'h000, 1}, '{32'h55a3, 16, 12'h5a3, 1}};
  adl_host_model i_host (.o_sclk(sclk), .o_cs_b(cs_b), .o_sdi(sdi));
  adl_code_loader i_dut (.i_mclk(mclk), .i_rst_b(rst_b), .i_sclk(sclk), .i_cs_b(cs_b),
    .i_sdi(sdi), .i_code_rst_b(crst_b), .i_standby_input_n(sb_n),
    .i_address_pin_2(pins[2]), .i_address_pin_1(pins[1]), .i_address_pin_0(pins[0]),
    .o_code(code), .o_load_pulse(pulse));
  // The clock toggles every 10 ns and load pulses are caught as they pass.
  always #10 mclk = ~mclk;
  always @(posedge mclk) if (pulse === 1'b1) got = 1'b1;
  // Compares one value against its expectation and counts the result.
  task automatic check(input logic [11:0] seen, input logic [11:0] exp);
    samples_checked++;
    if (seen !== exp)
    begin
      err_count++;
      $display("BAD %0t %h %h", $time, seen, exp);
    end
  endtask : check
  // Prints the verdict and stops the run.
  task end_of_test;
    if (err_count == 0 && samples_checked > 0)
      $display("All tests passed");
    else
      $display("Some tests failed");
    $finish;
  endtask : end_of_test
  // Table rows first, then standby, code reset and a strap change.
  initial
  begin
    repeat (2) @(negedge mclk);
    check(code, 12'h000);
    rst_b = 1'b1;
    foreach (rows[i])
    begin
      got = 1'b0;
      i_host.send(rows[i].w, rows[i].n);
      check(code, rows[i].c);
      check({11'h0, got}, {11'h0, rows[i].p});
    end
    sb_n = 1'b0;
    got = 1'b0;
    i_host.send(32'h5abc, 16);
    check(code, 12'h5a3);
    check({11'h0, got}, 12'h000);
    sb_n = 1'b1;
    crst_b = 1'b0;
    repeat (4) @(negedge mclk);
    check(code, 12'h000);
    crst_b = 1'b1;
    pins = 3'h0;
    got = 1'b0;
    i_host.send(32'h0800, 16);
    check(code, 12'h800);
    check({11'h0, got}, 12'h001);
    got = 1'b0;
    i_host.idle_clocks(16);
    i_host.send(32'h0, 0);
    check({11'h0, got}, 12'h001);
    check(code, 12'h800);
    end_of_test();
  end
  // A hung run is cut short well after the expected 25.5 us.
  initial
  begin
    #100us;
    err_count++;
    end_of_test();
  end
endmodule : adl_code_loader_tb
